// ==== verification/trace_cfg_bank_checker.sv ====
// trace_cfg_bank_checker: pin-level assertions for the settings bank.
// assumes: bound into trace_cfg_bank, one mclk domain.
`timescale 1ns/1ps
`default_nettype none
module trace_cfg_bank_checker
	import trace_cfg_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// serial pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdin,
	input wire logic sdout,
	input wire logic sdout_oe,
	// settings
	input wire trace_cfg_pkg::driver_cfg_t out0_rate3_cfg,
	input wire trace_cfg_pkg::driver_cfg_t out1_rate6_cfg
);
	////////////////////////////////
	wire driver_cfg_t o0 = out0_rate3_cfg;
	wire driver_cfg_t o1 = out1_rate6_cfg;
	logic [3:0] idle_r;
	logic [3:0] idle_nxt;
	// counts deselected cycles, saturating
	assign idle_nxt = (idle_r == 4'hF) ? idle_r : idle_r + 4'h1;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			idle_r <= 4'h0;
		else
			idle_r <= cs_n ? idle_nxt : 4'h0;
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	property p_rst(v, e);
		$rose(nrst) |-> v == e;
	endproperty

	////////////////////////////////
	a_width0_reset: assert property (p_rst(o0.emph.pulse_width, 5'h02))
		else $error("out0 width reset");
	a_power0_reset: assert property (p_rst(o0.emph.power_off, 1'b0))
		else $error("out0 power reset");
	a_ampl0_reset: assert property (p_rst(o0.emph.amplitude, 6'h01))
		else $error("out0 amplitude reset");
	a_swing0_reset: assert property (p_rst(o0.swing, 6'h11))
		else $error("out0 swing reset");
	a_width1_reset: assert property (p_rst(o1.emph.pulse_width, 5'h02))
		else $error("out1 width reset");
	a_power1_reset: assert property (p_rst(o1.emph.power_off, 1'b0))
		else $error("out1 power reset");
	a_ampl1_reset: assert property (p_rst(o1.emph.amplitude, 6'h01))
		else $error("out1 amplitude reset");
	a_swing1_reset: assert property (p_rst(o1.swing, 6'h11))
		else $error("out1 swing reset");
	a_cfg_idle_hold: assert property (idle_r > 4'h8 |-> $stable({o0, o1}))
		else $error("config moved while deselected");
	a_oe_idle_low: assert property (idle_r > 4'h8 |-> !sdout_oe)
		else $error("sdout driven while deselected");

	c_read_phase: cover property ($rose(sdout_oe));
	c_power_off: cover property ($rose(o1.emph.power_off));
	c_swing_max: cover property (o0.swing == 6'h28);
	c_data_high: cover property (!cs_n && sclk && sdin);
endmodule : trace_cfg_bank_checker

bind trace_cfg_bank trace_cfg_bank_checker trace_cfg_bank_checker_inst (
	.mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sdin(sdin),
	.sdout(sdout), .sdout_oe(sdout_oe),
	.out0_rate3_cfg(out0_rate3_cfg), .out1_rate6_cfg(out1_rate6_cfg)
);
`default_nettype wire

// ==== verification/trace_cfg_bank_tb.sv ====
// trace_cfg_bank_tb: serial-frame register tests of the settings bank.
// assumes: 50 MHz mclk; host keeps each sclk phase over 6 mclk.
`timescale 1ns/1ps
`default_nettype none
module trace_cfg_bank_tb;
	import trace_cfg_pkg::*;

	logic        mclk;
	logic        nrst;
	logic        sclk;
	logic        cs_n;
	logic        sdin;
	logic        sdout;
	logic        sdout_oe;
	driver_cfg_t o0;
	driver_cfg_t o1;
	logic [15:0] rd_v;
	logic        oe_v;
	logic [15:0] pat [2][4];
	int          err_count;
	int          check_count;

	trace_cfg_bank trace_cfg_bank_inst (
		.mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
		.sdin(sdin), .sdout(sdout), .sdout_oe(sdout_oe),
		.out0_rate3_cfg(o0), .out1_rate6_cfg(o1)
	);

	always #10 mclk = ~mclk;

	////////////////////////////////
	function automatic driver_cfg_t exp_cfg(logic [15:0] e, logic [15:0] s);
		return {e[12:8], e[6], e[5:0], s[13:8]};
	endfunction : exp_cfg

	task automatic check(input string what, input logic [17:0] seen,
			input logic [17:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	// 8 mclk per sclk phase leaves margin over the synchroniser delay
	task automatic frame(input logic [31:0] bits);
		cs_n <= 1'b0;
		repeat (8) @(posedge mclk);
		for (int i = 31; i >= 0; i--) begin
			sdin <= bits[i];
			repeat (8) @(posedge mclk);
			sclk <= 1'b1;
			rd_v = {rd_v[14:0], sdout};
			oe_v = sdout_oe;
			repeat (8) @(posedge mclk);
			sclk <= 1'b0;
		end
		repeat (8) @(posedge mclk);
		cs_n <= 1'b1;
		sdin <= 1'b0;
		repeat (12) @(posedge mclk);
	endtask : frame

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		frame({4'h0, a, d});
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
		frame({4'h8, a, 16'h0000});
		check("read word", {2'b00, rd_v}, {2'b00, e});
		check("read enable", {17'h00000, oe_v}, 18'h00001);
	endtask : rd_chk

	task automatic do_reset;
		nrst <= 1'b0;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		repeat (6) @(posedge mclk);
	endtask : do_reset

	task automatic reset_chk;
		check("out0", o0, exp_cfg(16'h0201, 16'h1170));
		check("out1", o1, exp_cfg(16'h0201, 16'h1170));
		for (int i = 0; i < 4; i++) begin
			rd_chk(OFS_OUT0_RATE3_EMPH + 12'(i),
				i[0] ? 16'h1170 : 16'h0201);
		end
	endtask : reset_chk

	////////////////////////////////
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		sclk = 1'b0;
		cs_n = 1'b1;
		sdin = 1'b0;
		rd_v = 16'h0000;
		oe_v = 1'b0;
		err_count = 0;
		check_count = 0;
		// field extremes with reserved bits kept at their reset levels
		pat = '{'{16'h0F72, 16'h2870, 16'h0000, 16'h0070},
			'{16'h0000, 16'h0070, 16'h0F72, 16'h2870}};
		do_reset();
		reset_chk();
		$display("test reset values done");
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 4; i++) begin
				wr(OFS_OUT0_RATE3_EMPH + 12'(i), pat[p][i]);
			end
			for (int i = 0; i < 4; i++) begin
				rd_chk(OFS_OUT0_RATE3_EMPH + 12'(i), pat[p][i]);
			end
			check("out0", o0, exp_cfg(pat[p][0], pat[p][1]));
			check("out1", o1, exp_cfg(pat[p][2], pat[p][3]));
		end
		$display("test field write done");
		wr(12'h036, 16'hFFFF);
		rd_chk(12'h036, 16'h0000);
		rd_chk(12'h035, 16'h2870);
		$display("test unmapped done");
		do_reset();
		reset_chk();
		$display("test second reset done");
		tally_and_finish();
	end

	initial begin
		repeat (40000) @(posedge mclk);
		err_count++;
		tally_and_finish();
	end
endmodule : trace_cfg_bank_tb
`default_nettype wire

// ==== verilog/cfg_word.sv ====
// cfg_word: one 16-bit read/write configuration word.
// assumes: write strobe is a one-cycle pulse on mclk; every bit, the
// reserved ones included, is stored so readback returns what was written.

`timescale 1ns/1ps
`default_nettype none

module cfg_word #(
	parameter int          W       = 16,
	parameter logic [15:0] RST_VAL = 16'h0000
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         nrst,
	// write port
	input  wire logic         wr_stb,
	input  wire logic [W-1:0] wr_data,
	// stored word
	output var  logic [W-1:0] word
);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			word <= RST_VAL[W-1:0];
		end else if (wr_stb) begin
			word <= wr_data;
		end
	end

endmodule : cfg_word

`default_nettype wire

// ==== verilog/pin_sync.sv ====
// pin_sync: three-stage synchroniser for one pin with agreement filter.
// assumes: pin is asynchronous to mclk; output changes only when the
// second and third stages agree.

`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// pin and filtered level
	input  wire logic pin,
	output var  logic level
);

	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic agree;

	// s1_r feeds s2_r only, to keep metastability contained
	assign agree = (s2_r == s3_r);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s1_r  <= RST_VAL;
			s2_r  <= RST_VAL;
			s3_r  <= RST_VAL;
			level <= RST_VAL;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (agree) begin
				level <= s3_r;
			end
		end
	end

endmodule : pin_sync

`default_nettype wire

// ==== verilog/trace_cfg_bank.sv ====
// trace_cfg_bank: serial-accessed settings bank for the trace driver,
// rate 3 on output zero and rate 6 on output one.
// assumes: host drives sclk, cs_n and sdin as a plain serial master;
// all pins are asynchronous to mclk and much slower than it.
//
// Functional notes
// RL1: out0 rate3 pulse width, bits 12:8, reset 2
// RL2: out0 rate3 emphasis power-off bit 6, reset 0
// RL3: out0 rate3 emphasis amplitude, bits 5:0, reset 1
// RL4: out0 rate3 swing, bits 13:8, reset 11h
// RL5: out1 rate6 pulse width, bits 12:8, reset 2
// RL6: out1 rate6 emphasis power-off bit 6, reset 0
// RL7: out1 rate6 emphasis amplitude, bits 5:0, reset 1
// RL8: out1 rate6 swing, bits 13:8, reset 11h
// RL9: host preserves reserved bits when writing
// RL10: host writes only in-range field codes

`timescale 1ns/1ps
`default_nettype none

module trace_cfg_bank
	import trace_cfg_pkg::*;
(
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 nrst,
	// serial control pins
	input  wire logic                 sclk,
	input  wire logic                 cs_n,
	input  wire logic                 sdin,
	output var  logic                 sdout,
	output var  logic                 sdout_oe,
	// settings toward the analogue drivers
	output var  trace_cfg_pkg::driver_cfg_t out0_rate3_cfg,
	output var  trace_cfg_pkg::driver_cfg_t out1_rate6_cfg
);

	import trace_cfg_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic sclk_f;
	logic cs_n_f;
	logic sdin_f;

	pin_sync #(
		.RST_VAL (1'b0)
	) u_sync_sclk (
		.mclk  (mclk),
		.nrst  (nrst),
		.pin   (sclk),
		.level (sclk_f)
	);

	// chip select idles high so a reset never looks like a frame start
	pin_sync #(
		.RST_VAL (1'b1)
	) u_sync_cs (
		.mclk  (mclk),
		.nrst  (nrst),
		.pin   (cs_n),
		.level (cs_n_f)
	);

	pin_sync #(
		.RST_VAL (1'b0)
	) u_sync_sdin (
		.mclk  (mclk),
		.nrst  (nrst),
		.pin   (sdin),
		.level (sdin_f)
	);

	////////////////////////////////////////////////////////////////////////
	// serial clock edges

	logic sclk_prev_r;
	logic sclk_rise;
	logic sclk_fall;
	logic frame_on;

	assign frame_on  = ~cs_n_f;
	assign sclk_rise = frame_on & sclk_f & ~sclk_prev_r;
	assign sclk_fall = frame_on & ~sclk_f & sclk_prev_r;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sclk_prev_r <= 1'b0;
		end else begin
			sclk_prev_r <= sclk_f;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame state

	frame_state_t            state_r;
	frame_state_t            state_nxt;
	logic [WORD_W-1:0]       shift_in_r;
	logic [WORD_W-1:0]       shift_in_nxt;
	logic [BIT_CNT_W-1:0]    bit_cnt_r;
	logic [BIT_CNT_W-1:0]    bit_cnt_nxt;
	logic                    read_r;
	logic                    read_nxt;
	logic [ADDR_W-1:0]       addr_r;
	logic [ADDR_W-1:0]       addr_nxt;
	logic [WORD_W-1:0]       shift_out_r;
	logic [WORD_W-1:0]       shift_out_nxt;
	logic                    wr_stb_r;
	logic                    wr_stb_nxt;
	logic [WORD_W-1:0]       wr_data_r;
	logic [ADDR_W-1:0]       wr_addr_r;
	logic                    sdout_nxt;
	logic                    sdout_oe_nxt;

	logic [WORD_W-1:0]       word_in;
	logic                    word_done;
	logic [ADDR_W-1:0]       addr_inc;
	logic [ADDR_W-1:0]       look_addr;
	logic [WORD_W-1:0]       rd_data;

	assign word_in   = {shift_in_r[WORD_W-2:0], sdin_f};
	assign word_done = sclk_rise && (bit_cnt_r == {BIT_CNT_W{1'b1}});
	assign addr_inc  = addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
	// the word to be shifted out next: the one just addressed by the
	// command, or the following one in a burst
	assign look_addr = (state_r == ST_CMD) ?
		word_in[CMD_ADDR_MSB:CMD_ADDR_LSB] : addr_inc;

	////////////////////////////////////////////////////////////////////////
	// stored words

	logic [WORD_W-1:0] emph0_word;
	logic [WORD_W-1:0] swing0_word;
	logic [WORD_W-1:0] emph1_word;
	logic [WORD_W-1:0] swing1_word;
	logic              hit_emph0;
	logic              hit_swing0;
	logic              hit_emph1;
	logic              hit_swing1;

	assign hit_emph0  = wr_stb_r && (wr_addr_r == OFS_OUT0_RATE3_EMPH);
	assign hit_swing0 = wr_stb_r && (wr_addr_r == OFS_OUT0_RATE3_SWING);
	assign hit_emph1  = wr_stb_r && (wr_addr_r == OFS_OUT1_RATE6_EMPH);
	assign hit_swing1 = wr_stb_r && (wr_addr_r == OFS_OUT1_RATE6_SWING);

	// reserved bits are stored as written; keeping them is up to the host
	cfg_word #(
		.W       (WORD_W),
		.RST_VAL (RST_EMPH_WORD)
	) u_emph0 (
		.mclk    (mclk),
		.nrst    (nrst),
		.wr_stb  (hit_emph0),
		.wr_data (wr_data_r),
		.word    (emph0_word)
	); // see RL1 see RL2 see RL3 see RL9

	cfg_word #(
		.W       (WORD_W),
		.RST_VAL (RST_SWING_WORD)
	) u_swing0 (
		.mclk    (mclk),
		.nrst    (nrst),
		.wr_stb  (hit_swing0),
		.wr_data (wr_data_r),
		.word    (swing0_word)
	); // see RL4 see RL9

	cfg_word #(
		.W       (WORD_W),
		.RST_VAL (RST_EMPH_WORD)
	) u_emph1 (
		.mclk    (mclk),
		.nrst    (nrst),
		.wr_stb  (hit_emph1),
		.wr_data (wr_data_r),
		.word    (emph1_word)
	); // see RL5 see RL6 see RL7 see RL9

	cfg_word #(
		.W       (WORD_W),
		.RST_VAL (RST_SWING_WORD)
	) u_swing1 (
		.mclk    (mclk),
		.nrst    (nrst),
		.wr_stb  (hit_swing1),
		.wr_data (wr_data_r),
		.word    (swing1_word)
	); // see RL8 see RL9

	// field slices; the stored words are flops so outputs stay registered
	assign out0_rate3_cfg.emph.pulse_width =
		emph0_word[EMPH_WIDTH_MSB:EMPH_WIDTH_LSB]; // see RL1
	assign out0_rate3_cfg.emph.power_off =
		emph0_word[EMPH_POWER_BIT]; // see RL2
	assign out0_rate3_cfg.emph.amplitude =
		emph0_word[EMPH_AMPL_MSB:EMPH_AMPL_LSB]; // see RL3
	assign out0_rate3_cfg.swing =
		swing0_word[SWING_MSB:SWING_LSB]; // see RL4
	assign out1_rate6_cfg.emph.pulse_width =
		emph1_word[EMPH_WIDTH_MSB:EMPH_WIDTH_LSB]; // see RL5
	assign out1_rate6_cfg.emph.power_off =
		emph1_word[EMPH_POWER_BIT]; // see RL6
	assign out1_rate6_cfg.emph.amplitude =
		emph1_word[EMPH_AMPL_MSB:EMPH_AMPL_LSB]; // see RL7
	assign out1_rate6_cfg.swing =
		swing1_word[SWING_MSB:SWING_LSB]; // see RL8

	////////////////////////////////////////////////////////////////////////
	// read selection; unmapped offsets read as zero

	assign rd_data =
		(look_addr == OFS_OUT0_RATE3_EMPH)  ? emph0_word  :
		(look_addr == OFS_OUT0_RATE3_SWING) ? swing0_word :
		(look_addr == OFS_OUT1_RATE6_EMPH)  ? emph1_word  :
		(look_addr == OFS_OUT1_RATE6_SWING) ? swing1_word :
		16'h0000;

	////////////////////////////////////////////////////////////////////////
	// frame engine

	always_comb begin
		state_nxt     = state_r;
		shift_in_nxt  = shift_in_r;
		bit_cnt_nxt   = bit_cnt_r;
		read_nxt      = read_r;
		addr_nxt      = addr_r;
		shift_out_nxt = shift_out_r;
		wr_stb_nxt    = 1'b0;
		sdout_nxt     = sdout;
		sdout_oe_nxt  = frame_on && read_r && (state_r == ST_DATA);
		if (!frame_on) begin
			// a frame cut short drops its partial word
			state_nxt    = ST_CMD;
			bit_cnt_nxt  = {BIT_CNT_W{1'b0}};
			read_nxt     = 1'b0;
			sdout_nxt    = 1'b0;
			sdout_oe_nxt = 1'b0;
		end else if (sclk_rise) begin
			shift_in_nxt = word_in;
			bit_cnt_nxt  = bit_cnt_r + {{(BIT_CNT_W-1){1'b0}}, 1'b1};
			if (word_done) begin
				case (state_r)
					ST_CMD: begin
						state_nxt = ST_DATA;
						read_nxt  = word_in[CMD_READ_BIT];
						addr_nxt  = word_in[CMD_ADDR_MSB:CMD_ADDR_LSB];
						if (word_in[CMD_READ_BIT]) begin
							shift_out_nxt = rd_data;
						end
					end
					ST_DATA: begin
						// bursts walk upward one word per data word
						addr_nxt = addr_inc;
						if (read_r) begin
							shift_out_nxt = rd_data;
						end else begin
							wr_stb_nxt = 1'b1;
						end
					end
					default: begin
						state_nxt = ST_CMD;
					end
				endcase
			end
		end else if (sclk_fall && read_r && (state_r == ST_DATA)) begin
			sdout_nxt     = shift_out_r[WORD_W-1];
			shift_out_nxt = {shift_out_r[WORD_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_r     <= ST_CMD;
			shift_in_r  <= 16'h0000;
			bit_cnt_r   <= 4'h0;
			read_r      <= 1'b0;
			addr_r      <= 12'h000;
			shift_out_r <= 16'h0000;
			wr_stb_r    <= 1'b0;
			wr_data_r   <= 16'h0000;
			wr_addr_r   <= 12'h000;
			sdout       <= 1'b0;
			sdout_oe    <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			shift_in_r  <= shift_in_nxt;
			bit_cnt_r   <= bit_cnt_nxt;
			read_r      <= read_nxt;
			addr_r      <= addr_nxt;
			shift_out_r <= shift_out_nxt;
			wr_stb_r    <= wr_stb_nxt;
			sdout       <= sdout_nxt;
			sdout_oe    <= sdout_oe_nxt;
			if (wr_stb_nxt) begin
				wr_data_r <= word_in;
				wr_addr_r <= addr_r;
			end
		end
	end

endmodule : trace_cfg_bank

`default_nettype wire

// ==== verilog/trace_cfg_pkg.sv ====
// trace_cfg_pkg: constants, field layouts and carrier types of the
// trace driver rate settings bank.
// assumes: imported by trace_cfg_bank, its checker and its testbench.

package trace_cfg_pkg;

	////////////////////////////////////////////////////////////////////////
	// serial frame layout
	localparam int          WORD_W       = 16;
	localparam int          ADDR_W       = 12;
	localparam int          BIT_CNT_W    = 4;
	localparam int          CMD_READ_BIT = 15;
	localparam int          CMD_ADDR_MSB = 11;
	localparam int          CMD_ADDR_LSB = 0;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [11:0] OFS_OUT0_RATE3_EMPH  = 12'h032;
	localparam logic [11:0] OFS_OUT0_RATE3_SWING = 12'h033;
	localparam logic [11:0] OFS_OUT1_RATE6_EMPH  = 12'h034;
	localparam logic [11:0] OFS_OUT1_RATE6_SWING = 12'h035;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int          EMPH_WIDTH_MSB = 12;
	localparam int          EMPH_WIDTH_LSB = 8;
	localparam int          EMPH_POWER_BIT = 6;
	localparam int          EMPH_AMPL_MSB  = 5;
	localparam int          EMPH_AMPL_LSB  = 0;
	localparam int          SWING_MSB      = 13;
	localparam int          SWING_LSB      = 8;

	////////////////////////////////////////////////////////////////////////
	// reset values, reserved bits included
	// emphasis word: width 2, power on, amplitude 1
	localparam logic [15:0] RST_EMPH_WORD  = 16'h0201;
	// swing word: swing 11h, reserved low byte 70h
	localparam logic [15:0] RST_SWING_WORD = 16'h1170;

	////////////////////////////////////////////////////////////////////////
	// carrier types
	typedef struct packed {
		logic [4:0] pulse_width;
		logic       power_off;
		logic [5:0] amplitude;
	} emph_cfg_t;

	typedef struct packed {
		emph_cfg_t  emph;
		logic [5:0] swing;
	} driver_cfg_t;

	typedef enum logic {ST_CMD, ST_DATA} frame_state_t;

endpackage : trace_cfg_pkg
